/* File: rtl/spcs_pkg.sv */
// Purpose: Shared constants for the serial slave port and clock source logic
// Assumes: System clock at 25 MHz, byte-wide serial characters
// Notes: Serial format word holds polarity, phase and select level
package spcs_pkg;
  // Warmup of the high-frequency oscillator, in its own cycles
  localparam int WARMUP_CYCLES = 65536;
  localparam int WARMUP_W = 17;
  // Serial character size and bit counter width
  localparam int BYTE_BITS = 8;
  localparam int BITCNT_W = 4;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] FULL_BYTE = 4'h8;
  // Serial format field positions and width
  localparam int FMT_W = 3;
  localparam int FMT_POL = 0;
  localparam int FMT_PHA = 1;
  localparam int FMT_SSHI = 2;
  // Reset values: idle-low clock, active-edge sampling, active-low select
  localparam logic [2:0] FMT_RESET = 3'h0;
  localparam logic EXTERNAL_CLOCK_SELECT_RESET = 1'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {WARM_RESTART, WARM_WAIT, WARM_HF} spcs_warm_t;
endpackage

/* File: rtl/spcs_sync.sv */
// Purpose: Two-flop level synchroniser
// Assumes: Inputs are levels, not pulses
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module spcs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      q <= '0;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/spcs_top.sv */
// Purpose: Serial slave port with high-frequency clock source selection
// Assumes: Serial clock at most an eighth of clk_sys
`timescale 1ns/1ps
`default_nettype none
module spcs_top #(
  parameter int WARMUP_CYCLES = spcs_pkg::WARMUP_CYCLES
) (
  // System clock and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_rst_n,
  // High-frequency clock from the crystal input pin
  input wire logic crystal_input_pin,
  // Operating mode controls
  input wire logic stop_mode,
  input wire logic low_power_clock_mode,
  // Mirror values and apply strobe
  input wire logic [2:0] mirror_serial_format,
  input wire logic mirror_external_clock_select,
  input wire logic apply_mirror_command,
  // Clock source status and live serial format
  output logic clock_on_high_freq,
  output logic crystal_osc_enable,
  output logic external_clock_select,
  output logic [2:0] serial_format_config,
  // Serial pins
  input wire logic sclk,
  input wire logic ssel,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Byte interface to the core
  input wire logic [7:0] tx_data,
  output logic [7:0] rx_data,
  output logic rx_valid,
  // Interrupt request
  input wire logic irq_pending,
  output logic irq_n
);
  spcs_pkg::spcs_warm_t warm_state;
  logic restart_req;
  logic restart_x;
  logic [spcs_pkg::WARMUP_W-1:0] warm_cnt;
  logic warm_done_x;
  logic ack_x;
  logic [1:0] back_sync;
  logic ack_s;
  logic done_s;
  logic [2:0] pins_s;
  logic sclk_s;
  logic ssel_s;
  logic mosi_s;
  logic sclk_d;
  logic ss_act;
  logic ss_act_d;
  logic ss_start;
  logic lead_edge;
  logic trail_edge;
  logic cpol;
  logic cpha;
  logic [3:0] bit_cnt;
  logic byte_locked;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;

  // Warmup counter on the crystal clock
  spcs_sync #(.W(1)) u_restart_sync (
    .clk(crystal_input_pin),
    .rst_n(1'b1),
    .d(restart_req),
    .q(restart_x)
  );

  always_ff @(posedge crystal_input_pin)
  begin
    if (restart_x)
      warm_cnt <= '0;
    else if (!warm_done_x)
      warm_cnt <= warm_cnt + 1'b1;
  end

  always_ff @(posedge crystal_input_pin)
  begin
    if (restart_x)
      warm_done_x <= 1'b0;
    else if (warm_cnt == spcs_pkg::WARMUP_W'(WARMUP_CYCLES - 1))
      warm_done_x <= 1'b1;
  end

  always_ff @(posedge crystal_input_pin)
  begin
    ack_x <= restart_x;
  end

  spcs_sync #(.W(2)) u_back_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d({ack_x, warm_done_x}),
    .q(back_sync)
  );
  assign ack_s = back_sync[1];
  assign done_s = back_sync[0];

  // Restart handshake; a silent crystal leaves the state in RESTART
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !por_rst_n || stop_mode)
      warm_state <= spcs_pkg::WARM_RESTART;
    else
    begin
      case (warm_state)
        spcs_pkg::WARM_RESTART:
          if (ack_s)
            warm_state <= spcs_pkg::WARM_WAIT;
        spcs_pkg::WARM_WAIT:
          if (!ack_s && done_s)
            warm_state <= spcs_pkg::WARM_HF;
        spcs_pkg::WARM_HF:
          warm_state <= spcs_pkg::WARM_HF;
        default:
          warm_state <= spcs_pkg::WARM_RESTART;
      endcase
    end
  end
  // Registered so the crossing never sees a decode glitch
  always_ff @(posedge clk_sys)
  begin
    restart_req <= (warm_state == spcs_pkg::WARM_RESTART);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !por_rst_n)
      clock_on_high_freq <= 1'b0;
    else
      clock_on_high_freq <= (warm_state == spcs_pkg::WARM_HF) &&
        !low_power_clock_mode && !stop_mode;
  end

  // External clock select survives all but power-on reset
  always_ff @(posedge clk_sys)
  begin
    if (!por_rst_n)
      external_clock_select <= spcs_pkg::EXTERNAL_CLOCK_SELECT_RESET;
    else if (rst_n && apply_mirror_command)
      external_clock_select <= mirror_external_clock_select;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !por_rst_n)
      crystal_osc_enable <= 1'b0;
    else
      crystal_osc_enable <= !external_clock_select && !stop_mode;
  end

  // Live serial format
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !por_rst_n)
      serial_format_config <= spcs_pkg::FMT_RESET;
    else if (apply_mirror_command)
      serial_format_config <= mirror_serial_format;
  end
  assign cpol = serial_format_config[spcs_pkg::FMT_POL];
  assign cpha = serial_format_config[spcs_pkg::FMT_PHA];

  // Serial pins into the system domain
  // Select travels inverted so a cleared stage reads as deselected
  spcs_sync #(.W(3)) u_pin_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d({sclk, !ssel, mosi}),
    .q(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign ssel_s = !pins_s[1];
  assign mosi_s = pins_s[0];
  assign ss_act = ssel_s == serial_format_config[spcs_pkg::FMT_SSHI];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sclk_d <= 1'b0;
      ss_act_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_s;
      ss_act_d <= ss_act;
    end
  end
  assign ss_start = ss_act && !ss_act_d;
  // Active edge leaves the idle level
  assign lead_edge = ss_act && (sclk_s != cpol) && (sclk_d == cpol);
  assign trail_edge = ss_act && (sclk_s == cpol) && (sclk_d != cpol);

  // Bit counter and byte framing
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !ss_act)
    begin
      bit_cnt <= '0;
      byte_locked <= 1'b0;
    end
    else if (!cpha)
    begin
      if (ss_start)
      begin
        bit_cnt <= '0;
        byte_locked <= 1'b0;
      end
      else if (lead_edge && !byte_locked)
      begin
        bit_cnt <= bit_cnt + 1'b1;
        byte_locked <= (bit_cnt == spcs_pkg::LAST_BIT);
      end
    end
    else if (trail_edge && bit_cnt != '0)
      bit_cnt <= (bit_cnt == spcs_pkg::FULL_BYTE) ? 4'h0 : bit_cnt;
    else if (lead_edge)
      bit_cnt <= bit_cnt + 1'b1;
  end

  // Receive shift, MSB first
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      rx_shift <= spcs_pkg::BYTE_ZERO;
    else if ((!cpha && lead_edge && !byte_locked) || (cpha && trail_edge))
      rx_shift <= {rx_shift[6:0], mosi_s};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_data <= spcs_pkg::BYTE_ZERO;
      rx_valid <= 1'b0;
    end
    else if ((!cpha && lead_edge && !byte_locked &&
              bit_cnt == spcs_pkg::LAST_BIT) ||
             (cpha && trail_edge && bit_cnt == spcs_pkg::FULL_BYTE))
    begin
      rx_data <= {rx_shift[6:0], mosi_s};
      rx_valid <= 1'b1;
    end
    else
      rx_valid <= 1'b0;
  end

  // Transmit shift, one bit out per bit in
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      tx_shift <= spcs_pkg::BYTE_ZERO;
    else if (!cpha && ss_start)
      tx_shift <= tx_data;
    else if (!cpha && trail_edge && !byte_locked && bit_cnt != '0)
      tx_shift <= {tx_shift[6:0], 1'b0};
    else if (cpha && lead_edge)
      tx_shift <= (bit_cnt == '0) ? tx_data : {tx_shift[6:0], 1'b0};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
    end
    else
    begin
      miso <= tx_shift[7];
      miso_oe_n <= !ss_act;
    end
  end

  // Interrupt line, active low
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !por_rst_n)
      irq_n <= 1'b1;
    else
      irq_n <= !irq_pending;
  end

  // Checks
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  sequence s_warm_ready;
    warm_state == spcs_pkg::WARM_WAIT && !ack_s && done_s;
  endsequence
  sequence s_clean_run;
    rst_n && por_rst_n && !stop_mode;
  endsequence

  AST_AUTO_SWITCH: assert property (disable iff (!rst_n)
    (s_warm_ready and s_clean_run) |=> warm_state == spcs_pkg::WARM_HF)
    else $error("no switch after warmup");
  AST_NO_EARLY_HF: assert property (disable iff (!rst_n)
    clock_on_high_freq |-> $past(warm_state) == spcs_pkg::WARM_HF)
    else $error("fast clock before warmup");
  AST_STOP_RESTART: assert property (disable iff (!rst_n)
    stop_mode |=> warm_state == spcs_pkg::WARM_RESTART && !clock_on_high_freq)
    else $error("stop did not restart warmup");
  AST_LOW_POWER_CLOCK_MODE_RC: assert property (disable iff (!rst_n)
    low_power_clock_mode |=> !clock_on_high_freq)
    else $error("low power mode on fast clock");
  AST_EXT_OSC_OFF: assert property (disable iff (!rst_n)
    external_clock_select |=> !crystal_osc_enable)
    else $error("oscillator on with external clock");
  AST_EXT_KEEP: assert property ((por_rst_n && !rst_n)[*2] |->
    $stable(external_clock_select))
    else $error("external select lost on system reset");
  AST_FMT_RESET: assert property (!rst_n |=>
    serial_format_config == spcs_pkg::FMT_RESET)
    else $error("format not default after reset");
  AST_APPLY: assert property (disable iff (!rst_n)
    (apply_mirror_command && por_rst_n) |=>
      serial_format_config == $past(mirror_serial_format) &&
      external_clock_select == $past(mirror_external_clock_select))
    else $error("apply did not load mirror");
  AST_FMT_HOLD: assert property (disable iff (!rst_n)
    (!apply_mirror_command && por_rst_n) |=> $stable(serial_format_config))
    else $error("format changed without apply");
  AST_PHA0_LOCK: assert property (disable iff (!rst_n)
    (!cpha && byte_locked && ss_act && !apply_mirror_command) |=>
      !rx_valid && byte_locked)
    else $error("second byte without new select");
  AST_PHA1_LOAD: assert property (disable iff (!rst_n)
    (cpha && lead_edge && bit_cnt == '0 && !apply_mirror_command) |=>
      ##1 miso == $past(tx_data[7], 2))
    else $error("byte start did not present msb");
  AST_IRQ: assert property (disable iff (!rst_n)
    (irq_pending && por_rst_n) |=> !irq_n)
    else $error("interrupt not signalled");
endmodule
`default_nettype wire

/* File: verification/spcs_master.sv */
// Purpose: Serial bus master model for the slave port
// Assumes: Paced by the system clock, half period of 8 cycles
// Notes: Tasks are called from the bench
`timescale 1ns/1ps
`default_nettype none
module spcs_master (
  // Pacing clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic ssel,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  localparam int HALF = 8;
  logic oe_ok;
  initial
  begin
    sclk = 1'b0;
    ssel = 1'b1;
    mosi = 1'b0;
    oe_ok = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Idle clock level, select inactive
  task automatic park(input logic [2:0] fmt);
    tick(1);
    sclk = fmt[0];
    ssel = ~fmt[2];
  endtask
  task automatic xfer(input logic [2:0] fmt, input logic [7:0] tx,
                      input logic hold, output logic [7:0] rx);
    oe_ok = 1'b1;
    tick(1);
    if (ssel !== fmt[2])
    begin
      ssel = fmt[2];
      tick(HALF);
    end
    for (int i = 7; i >= 0; i--)
    begin
      if (fmt[1] == 1'b0)
      begin
        mosi = tx[i];
        tick(HALF);
        sclk = ~fmt[0];
        rx[i] = miso;
        tick(HALF);
        sclk = fmt[0];
      end
      else
      begin
        sclk = ~fmt[0];
        mosi = tx[i];
        tick(HALF);
        sclk = fmt[0];
        rx[i] = miso;
        tick(HALF);
      end
      oe_ok = oe_ok & (miso_oe_n === 1'b0);
    end
    tick(HALF);
    if (!hold)
    begin
      ssel = ~fmt[2];
    end
    mosi = ~mosi;
    tick(400);
  endtask
endmodule
`default_nettype wire

/* File: verification/spcs_top_tb.sv */
// Purpose: Self-checking bench for the serial port and clock source
// Assumes: Short warmup count, crystal clock of 64 ns
// Notes: Inputs change at the falling edge of clk_sys
`timescale 1ns/1ps
`default_nettype none
module spcs_top_tb;
  localparam int WARM = 16;
  logic clk_sys, rst_n, por_rst_n, crystal_input_pin, xtal_run;
  logic stop_mode, low_power_clock_mode, apply_mirror_command;
  logic mirror_external_clock_select, irq_pending, irq_n;
  logic [2:0] mirror_serial_format, serial_format_config, fmt;
  logic clock_on_high_freq, crystal_osc_enable, external_clock_select;
  logic sclk, ssel, mosi, miso, miso_oe_n, rx_valid;
  logic [7:0] tx_data, rx_data, rx_cap, x, got;
  logic [31:0] seed;
  int failures = 0;
  int check_count = 0;
  int rx_count = 0;
  int cnt;
  spcs_top #(.WARMUP_CYCLES(WARM)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .por_rst_n(por_rst_n), .crystal_input_pin(crystal_input_pin),
    .stop_mode(stop_mode), .low_power_clock_mode(low_power_clock_mode),
    .mirror_serial_format(mirror_serial_format),
    .mirror_external_clock_select(mirror_external_clock_select),
    .apply_mirror_command(apply_mirror_command),
    .clock_on_high_freq(clock_on_high_freq),
    .crystal_osc_enable(crystal_osc_enable),
    .external_clock_select(external_clock_select),
    .serial_format_config(serial_format_config), .sclk(sclk),
    .ssel(ssel), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .tx_data(tx_data), .rx_data(rx_data), .rx_valid(rx_valid),
    .irq_pending(irq_pending), .irq_n(irq_n));
  spcs_master u_master (.clk(clk_sys), .sclk(sclk), .ssel(ssel),
    .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Oscillates only when powered or fed externally
  initial
  begin
    crystal_input_pin = 1'b0;
    #7;
    forever
    begin
      #32;
      if (xtal_run && (crystal_osc_enable || external_clock_select))
        crystal_input_pin = ~crystal_input_pin;
    end
  end
  always @(posedge clk_sys)
  begin
    if (rx_valid === 1'b1)
    begin
      rx_cap <= rx_data;
      rx_count <= rx_count + 1;
    end
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic cmp_bit(input logic g, input logic e, input string what);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: %s got %b", $time, what, g);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e,
                          input string what);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask
  task automatic do_reset(input logic por);
    rst_n = 1'b0;
    por_rst_n = ~por;
    tick(3);
    rst_n = 1'b1;
    por_rst_n = 1'b1;
    tick(1);
  endtask
  task automatic apply(input logic [2:0] f, input logic ext);
    mirror_serial_format = f;
    mirror_external_clock_select = ext;
    apply_mirror_command = 1'b1;
    tick(1);
    apply_mirror_command = 1'b0;
    tick(1);
  endtask
  task automatic wait_hf();
    int n;
    n = 0;
    while (clock_on_high_freq !== 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    cmp_bit(clock_on_high_freq, 1'b1, "fast clock");
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #(40000 * 40);
    failures++;
    print_verdict();
  end
  initial
  begin
    {rst_n, por_rst_n, stop_mode, low_power_clock_mode} = 4'h0;
    {apply_mirror_command, mirror_external_clock_select} = 2'h0;
    {irq_pending, xtal_run} = 2'h1;
    mirror_serial_format = 3'h0;
    tx_data = 8'h00;
    seed = 32'h11B2876E;
    do_reset(1'b1);
    cmp_byte({5'h00, serial_format_config}, 8'h00, "format");
    cmp_bit(miso_oe_n, 1'b1, "miso enable");
    cmp_bit(external_clock_select, 1'b0, "ext select");
    tick(10);
    cmp_bit(clock_on_high_freq, 1'b0, "rc in warmup");
    wait_hf();
    low_power_clock_mode = 1'b1;
    tick(2);
    cmp_bit(clock_on_high_freq, 1'b0, "low power");
    low_power_clock_mode = 1'b0;
    wait_hf();
    stop_mode = 1'b1;
    tick(3);
    cmp_bit(crystal_osc_enable, 1'b0, "osc in stop");
    stop_mode = 1'b0;
    tick(4);
    cmp_bit(clock_on_high_freq, 1'b0, "warmup restart");
    wait_hf();
    $display("test clock source done");
    apply(3'h0, 1'b1);
    cmp_bit(external_clock_select, 1'b1, "ext select");
    cmp_bit(crystal_osc_enable, 1'b0, "osc off");
    do_reset(1'b0);
    cmp_bit(external_clock_select, 1'b1, "ext kept");
    do_reset(1'b1);
    cmp_bit(external_clock_select, 1'b0, "ext cleared");
    wait_hf();
    xtal_run = 1'b0;
    do_reset(1'b0);
    tick(300);
    cmp_bit(clock_on_high_freq, 1'b0, "no crystal");
    xtal_run = 1'b1;
    wait_hf();
    $display("test external clock done");
    for (int m = 0; m < 8; m++)
    begin
      fmt = 3'(m);
      apply(fmt, 1'b0);
      cmp_byte({5'h00, serial_format_config}, {5'h00, fmt}, "cfg");
      u_master.park(fmt);
      tick(4);
      for (int b = 0; b < 2; b++)
      begin
        seed = next_rand(seed);
        tx_data = (m == 0) ? {7'h00, 1'(b)} : seed[7:0];
        x = (m == 0) ? {1'b1, {7{1'(b)}}} : seed[15:8];
        irq_pending = seed[16];
        cnt = rx_count;
        u_master.xfer(fmt, x, fmt[1] && b == 0, got);
        cmp_byte(got, tx_data, "miso byte");
        cmp_byte(rx_cap, x, "mosi byte");
        cmp_bit(rx_count == cnt + 1, 1'b1, "one byte");
        cmp_bit(u_master.oe_ok, 1'b1, "miso driven");
        cmp_bit(irq_n, ~irq_pending, "irq");
      end
      $display("test format %0d done", m);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
